// [rtl/monitor_ctrl.v]
// Function
// - Config bit 0 starts or halts monitoring
// - Config bit 1 enables interrupt output
// - Config bit 2 selects interrupt polarity/drive
// - Config bit 3 deasserts interrupt, pauses monitoring
// - Config bit 4 pulses reset-out when enabled
// - Config bit 5 pulls intrusion low 10ms
// - Config bit 6 drives general output low
// - Config bit 7 restores defaults, self-clears
// - Config at 00h, reset value 08h
// - Status1 bits 0-6 flag channel limits
// - Status1 bit 7 flags low chained input
// - Status2 bit 1 flags board-temp interrupt
// - Status2 bits 2,3 flag fan limits
// - Status2 bit 4 flags intrusion high
// - Status2 bit 0 hot temp, mode mask2.6
// - Status2 bit 5 overtemp, mode mask2.7
// - Status2 bits 6,7 reserved, read zero
// - Mask1 bits block status1 bits, reset 00h
// - Mask2 bits 0-5 block status2 bits
// - Mask2 bit 6 selects default/one-time mode
// - Mask2 bit 7 selects comparator/one-time mode
// - Mask2 at 04h, reset value 00h
// - Status read returns, clears, drops interrupt
// - External inputs raise interrupt when enabled
// - Answer only slave address 0101 plus pins
`timescale 1ns/1ps
`default_nettype none
`include "monitor_ctrl_defines.vh"

module monitor_ctrl #(
  parameter INTRUSION_CLR_CYCLES = (`CLK_FREQ_HZ / 1000) * `INTRUSION_CLR_MS,
  parameter RESET_PULSE_CYCLES   = (`CLK_FREQ_HZ / 1000000) * `RESET_PULSE_US
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rstn,
  // Serial bus pins
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda_oe,
  input  wire [2:0]  i_addr_pins,
  // Monitoring events, one-cycle or level from monitor logic
  input  wire [6:0]  i_channel_limit,
  input  wire        i_hot_limit,
  input  wire [1:0]  i_fan_limit,
  input  wire        i_overtemp_limit,
  // External interrupt pins
  input  wire        i_chain_irq_n,
  input  wire        i_board_temp_irq_input,
  input  wire        i_intrusion_input,
  // Pin drives
  output reg         o_intrusion_oe,
  output reg         o_irq_out,
  output reg         o_irq_oe,
  output reg         o_reset_out_n,
  output reg         o_general_output_pin_oe,
  output reg         o_monitor_run
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ACK  = 3'd2;
  localparam ST_RX   = 3'd3;
  localparam ST_TX   = 3'd4;
  localparam ST_TACK = 3'd5;
  localparam ST_SKIP = 3'd6;

  // Two-stage synchronisers for every pin
  // Reset levels match each pin's idle level, so no false edge follows reset
  reg [4:0] sync1_reg;
  reg [4:0] sync2_reg;
  reg [2:0] addr1_reg;
  reg [2:0] addr2_reg;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_reg <= 5'h1e;
      sync2_reg <= 5'h1e;
      addr1_reg <= 3'h0;
      addr2_reg <= 3'h0;
    end else begin
      sync1_reg <= {i_scl, i_sda, i_chain_irq_n, i_board_temp_irq_input,
                    i_intrusion_input};
      sync2_reg <= sync1_reg;
      addr1_reg <= i_addr_pins;
      addr2_reg <= addr1_reg;
    end
  end
  wire scl_s   = sync2_reg[4];
  wire sda_s   = sync2_reg[3];
  wire chain_s = sync2_reg[2];
  wire btemp_s = sync2_reg[1];
  wire intr_s  = sync2_reg[0];

  reg scl_d_reg;
  reg sda_d_reg;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
  wire bus_stop  = scl_s & scl_d_reg & sda_s & ~sda_d_reg;

  // Registers
  reg [7:0] config_reg;
  reg [7:0] status1_reg;
  reg [7:0] status2_reg;
  reg [7:0] mask1_reg;
  reg [7:0] mask2_reg;
  reg [7:0] fan_div_reg;
  reg [7:0] ptr_reg;

  // Serial slave state
  reg [2:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg       rw_reg;
  reg       ptr_phase_reg;
  reg       wr_pulse_reg;
  reg [7:0] wr_data_reg;
  reg       rd_pulse_reg;
  reg [7:0] rd_addr_reg;

  reg [7:0] rd_mux;
  always @* begin
    case (ptr_reg)
      `ADDR_CONFIG:        rd_mux = config_reg;
      `ADDR_STATUS_FIRST:  rd_mux = status1_reg;
      `ADDR_STATUS_SECOND: rd_mux = status2_reg & `ST2_EVENT_MASK;
      `ADDR_MASK_FIRST:    rd_mux = mask1_reg;
      `ADDR_MASK_SECOND:   rd_mux = mask2_reg;
      `ADDR_FAN_DIVISOR:   rd_mux = fan_div_reg;
      default:             rd_mux = 8'h00;
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      rw_reg        <= 1'b0;
      ptr_phase_reg <= 1'b0;
      wr_pulse_reg  <= 1'b0;
      wr_data_reg   <= 8'h00;
      rd_pulse_reg  <= 1'b0;
      rd_addr_reg   <= 8'h00;
      ptr_reg       <= 8'h00;
      o_sda_oe      <= 1'b0;
    end else begin
      wr_pulse_reg <= 1'b0;
      rd_pulse_reg <= 1'b0;
      if (bus_start) begin
        state_reg   <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        o_sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        o_sda_oe  <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              // Only our own address is acknowledged
              if (shift_reg[7:1] == {`SLAVE_ADDR_HI, addr2_reg}) begin
                rw_reg        <= shift_reg[0];
                ptr_phase_reg <= ~shift_reg[0];
                o_sda_oe      <= 1'b1;
                state_reg     <= ST_ACK;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (rw_reg) begin
                shift_reg   <= rd_mux;
                o_sda_oe    <= ~rd_mux[7];
                rd_addr_reg <= ptr_reg;
                rd_pulse_reg <= 1'b1;
                state_reg   <= ST_TX;
              end else begin
                o_sda_oe  <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              o_sda_oe <= 1'b1;
              state_reg <= ST_ACK;
              if (ptr_phase_reg) begin
                ptr_reg       <= shift_reg;
                ptr_phase_reg <= 1'b0;
              end else begin
                wr_pulse_reg <= 1'b1;
                wr_data_reg  <= shift_reg;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == 4'h7) begin
                o_sda_oe  <= 1'b0;
                state_reg <= ST_TACK;
              end else begin
                o_sda_oe  <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          ST_TACK: begin
            // A master nack ends the read
            if (scl_rise) begin
              state_reg <= sda_s ? ST_SKIP : ST_ACK;
            end
          end
          default: begin
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Event sources; monitor events count only while monitoring runs
  wire run = config_reg[`CFG_START] & ~config_reg[`CFG_INT_CLEAR];
  reg  chain_d_reg;
  reg  btemp_d_reg;
  reg  intr_d_reg;
  reg  hot_d_reg;
  reg  os_d_reg;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      chain_d_reg <= 1'b1;
      btemp_d_reg <= 1'b1;
      intr_d_reg  <= 1'b0;
      hot_d_reg   <= 1'b0;
      os_d_reg    <= 1'b0;
    end else begin
      chain_d_reg <= chain_s;
      btemp_d_reg <= btemp_s;
      intr_d_reg  <= intr_s;
      hot_d_reg   <= i_hot_limit;
      os_d_reg    <= i_overtemp_limit;
    end
  end

  // One-time mode sets on the rising edge only; default mode re-sets on level
  wire hot_ev = run & (mask2_reg[`MSK2_INT_MODE] ? (i_hot_limit & ~hot_d_reg)
                                                 : i_hot_limit);
  wire os_ev  = run & (mask2_reg[`MSK2_OS_MODE] ? (i_overtemp_limit & ~os_d_reg)
                                                : i_overtemp_limit);
  wire [7:0] set1 = {~chain_s & chain_d_reg,
                     i_channel_limit & {7{run}}};
  wire [7:0] set2 = {2'b00,
                     os_ev,
                     intr_s & ~intr_d_reg,
                     i_fan_limit & {2{run}},
                     ~btemp_s & btemp_d_reg,
                     hot_ev};

  wire clr1 = rd_pulse_reg & (rd_addr_reg == `ADDR_STATUS_FIRST);
  wire clr2 = rd_pulse_reg & (rd_addr_reg == `ADDR_STATUS_SECOND);
  wire wr_cfg = wr_pulse_reg & (ptr_reg == `ADDR_CONFIG);
  wire restore = wr_cfg & wr_data_reg[`CFG_RESTORE];

  // Self-clearing timers
  reg [31:0] intr_cnt_reg;
  reg [31:0] rst_cnt_reg;
  wire rst_allowed = fan_div_reg[`FAN_RST_EN] & ~fan_div_reg[`FAN_OS_EN];

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      config_reg   <= `RST_CONFIG;
      status1_reg  <= `RST_STATUS;
      status2_reg  <= `RST_STATUS;
      mask1_reg    <= `RST_MASK;
      mask2_reg    <= `RST_MASK;
      fan_div_reg  <= `RST_FAN_DIVISOR;
      intr_cnt_reg <= 32'h0;
      rst_cnt_reg  <= 32'h0;
    end else if (restore) begin
      // Restore bit itself is never stored, so it reads back as zero
      config_reg   <= `RST_CONFIG;
      status1_reg  <= `RST_STATUS;
      status2_reg  <= `RST_STATUS;
      mask1_reg    <= `RST_MASK;
      mask2_reg    <= `RST_MASK;
      fan_div_reg  <= `RST_FAN_DIVISOR;
      intr_cnt_reg <= 32'h0;
      rst_cnt_reg  <= 32'h0;
    end else begin
      // Set wins over the read clear
      status1_reg <= (clr1 ? 8'h00 : status1_reg) | set1;
      status2_reg <= (clr2 ? 8'h00 : status2_reg) | set2;
      if (wr_pulse_reg && ptr_reg == `ADDR_MASK_FIRST)
        mask1_reg <= wr_data_reg;
      if (wr_pulse_reg && ptr_reg == `ADDR_MASK_SECOND)
        mask2_reg <= wr_data_reg;
      if (wr_pulse_reg && ptr_reg == `ADDR_FAN_DIVISOR)
        fan_div_reg <= wr_data_reg;
      if (wr_cfg) begin
        config_reg <= {1'b0, wr_data_reg[6:4] & {1'b1, 1'b1, rst_allowed},
                       wr_data_reg[3:0]};
        intr_cnt_reg <= wr_data_reg[`CFG_INTRUSION_CLR] ? 32'h0 : intr_cnt_reg;
        rst_cnt_reg  <= wr_data_reg[`CFG_RESET_OUT] ? 32'h0 : rst_cnt_reg;
      end else begin
        if (config_reg[`CFG_INTRUSION_CLR]) begin
          if (intr_cnt_reg == INTRUSION_CLR_CYCLES - 1)
            config_reg[`CFG_INTRUSION_CLR] <= 1'b0;
          else
            intr_cnt_reg <= intr_cnt_reg + 32'h1;
        end
        if (config_reg[`CFG_RESET_OUT]) begin
          if (rst_cnt_reg == RESET_PULSE_CYCLES - 1)
            config_reg[`CFG_RESET_OUT] <= 1'b0;
          else
            rst_cnt_reg <= rst_cnt_reg + 32'h1;
        end
      end
    end
  end

  // Interrupt and pin outputs, all registered
  wire pend = |(status1_reg & ~mask1_reg) |
              |(status2_reg & `ST2_EVENT_MASK & ~mask2_reg);
  wire irq_active = config_reg[`CFG_INT_EN] & ~config_reg[`CFG_INT_CLEAR] & pend
                    & ~clr1 & ~clr2;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq_out               <= 1'b0;
      o_irq_oe                <= 1'b0;
      o_intrusion_oe          <= 1'b0;
      o_reset_out_n           <= 1'b1;
      o_general_output_pin_oe <= 1'b0;
      o_monitor_run           <= 1'b0;
    end else begin
      // High polarity drives high when active; low polarity pulls low when active
      o_irq_out               <= config_reg[`CFG_INT_POL];
      o_irq_oe                <= irq_active;
      o_intrusion_oe          <= config_reg[`CFG_INTRUSION_CLR];
      o_reset_out_n           <= ~config_reg[`CFG_RESET_OUT];
      o_general_output_pin_oe <= config_reg[`CFG_GPO];
      o_monitor_run           <= run;
    end
  end

endmodule // monitor_ctrl

`default_nettype wire

// [rtl/monitor_ctrl_defines.vh]
`ifndef MONITOR_CTRL_DEFINES_VH
`define MONITOR_CTRL_DEFINES_VH

// Register offsets
`define ADDR_CONFIG        8'h00
`define ADDR_STATUS_FIRST  8'h01
`define ADDR_STATUS_SECOND 8'h02
`define ADDR_MASK_FIRST    8'h03
`define ADDR_MASK_SECOND   8'h04
`define ADDR_FAN_DIVISOR   8'h05

// Reset values
`define RST_CONFIG         8'h08
`define RST_MASK           8'h00
`define RST_STATUS         8'h00
`define RST_FAN_DIVISOR    8'h14

// Configuration fields
`define CFG_START          0
`define CFG_INT_EN         1
`define CFG_INT_POL        2
`define CFG_INT_CLEAR      3
`define CFG_RESET_OUT      4
`define CFG_INTRUSION_CLR  5
`define CFG_GPO            6
`define CFG_RESTORE        7

// Status 2 fields
`define ST2_HOT            0
`define ST2_BOARD_TEMP     1
`define ST2_FAN1           2
`define ST2_FAN2           3
`define ST2_INTRUSION      4
`define ST2_OVERTEMP       5
`define ST2_EVENT_MASK     8'h3f

// Mask 2 mode fields
`define MSK2_INT_MODE      6
`define MSK2_OS_MODE       7

// Fan divisor pin-mode fields
`define FAN_OS_EN          6
`define FAN_RST_EN         7

// Bus slave address upper nibble
`define SLAVE_ADDR_HI      4'h5

// Timing, figures in their own units
`define CLK_FREQ_HZ        100000000
`define INTRUSION_CLR_MS   10
`define RESET_PULSE_US     10

`endif

// [sim/monitor_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module monitor_ctrl_chk #(
  parameter INTRUSION_CLR_CYCLES = 20,
  parameter RESET_PULSE_CYCLES   = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Observed pins
  input wire logic i_scl,
  input wire logic o_sda_oe,
  input wire logic o_intrusion_oe,
  input wire logic o_irq_out,
  input wire logic o_irq_oe,
  input wire logic o_reset_out_n,
  input wire logic o_general_output_pin_oe,
  input wire logic o_monitor_run
);
  int icnt;
  int rcnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Length of each pin pulse in clocks
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      icnt <= 0;
      rcnt <= 0;
    end else begin
      icnt <= o_intrusion_oe ? icnt + 1 : 0;
      rcnt <= o_reset_out_n ? 0 : rcnt + 1;
    end
  end
  sda_ack_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line moved while bus clock high");
  intr_len_a: assert property ($fell(o_intrusion_oe) |-> icnt == INTRUSION_CLR_CYCLES)
    else $error("intrusion clear pulse length wrong");
  intr_max_a: assert property (icnt <= INTRUSION_CLR_CYCLES)
    else $error("intrusion clear pulse too long");
  rst_len_a: assert property ($rose(o_reset_out_n) |-> rcnt == RESET_PULSE_CYCLES)
    else $error("reset pulse length wrong");
  rst_max_a: assert property (rcnt <= RESET_PULSE_CYCLES)
    else $error("reset pulse too long");
  rst_hold_a: assert property ($fell(o_reset_out_n) |=> !o_reset_out_n [*3])
    else $error("reset pulse cut short");
  irq_pol_a: assert property (o_irq_oe && $past(o_irq_oe) |-> $stable(o_irq_out))
    else $error("interrupt level moved while driven");
  reset_idle_a: assert property (disable iff (1'b0) !i_rstn |-> !o_irq_oe &&
    !o_monitor_run && o_reset_out_n && !o_intrusion_oe && !o_general_output_pin_oe)
    else $error("outputs not idle in reset");
  cover property ($rose(o_intrusion_oe));
  cover property ($fell(o_reset_out_n));
  cover property ($rose(o_irq_oe) && o_irq_out);
endmodule // monitor_ctrl_chk
bind monitor_ctrl monitor_ctrl_chk #(
  .INTRUSION_CLR_CYCLES(INTRUSION_CLR_CYCLES),
  .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) i_monitor_ctrl_chk (
  .i_clk(i_clk),
  .i_rstn(i_rstn),
  .i_scl(i_scl),
  .o_sda_oe(o_sda_oe),
  .o_intrusion_oe(o_intrusion_oe),
  .o_irq_out(o_irq_out),
  .o_irq_oe(o_irq_oe),
  .o_reset_out_n(o_reset_out_n),
  .o_general_output_pin_oe(o_general_output_pin_oe),
  .o_monitor_run(o_monitor_run)
);
`default_nettype wire

// [sim/smbus_host.sv]
`timescale 1ns/1ps
`default_nettype none
module smbus_host (
  // Clock
  input  wire logic i_clk,
  // Bus wires
  input  wire logic i_sda_oe,
  output var  logic o_scl,
  output wire logic o_sda
);
  logic sda_low;
  logic odd;
  // Pull-up: the line reads high unless a party pulls it
  assign o_sda = !(sda_low | i_sda_oe);
  initial begin
    o_scl = 1'b1;
    sda_low = 1'b0;
    odd = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Six clocks low, six or seven high: 125 ns per bit on average
  task automatic bit_io(input logic b, output logic r);
    wt(3);
    sda_low = !b;
    wt(3);
    o_scl = 1'b1;
    odd = !odd;
    wt(3);
    r = o_sda;
    wt(3 + int'(odd));
    o_scl = 1'b0;
  endtask
  // Ninth bit released: slave ack on writes, master nack on reads
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic start_c;
    sda_low = 1'b1;
    wt(6);
    o_scl = 1'b0;
  endtask
  task automatic stop_c;
    wt(3);
    sda_low = 1'b1;
    wt(3);
    o_scl = 1'b1;
    wt(6);
    sda_low = 1'b0;
    wt(6);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] p, d, input logic full,
                           output logic nak);
    logic [7:0] q;
    logic n0;
    logic n1;
    logic n2;
    start_c();
    byte_io({dev, 1'b0}, q, n0);
    byte_io(p, q, n1);
    n2 = 1'b0;
    if (full) begin
      byte_io(d, q, n2);
    end
    stop_c();
    nak = n0 | n1 | n2;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] q);
    logic [7:0] x;
    logic n;
    write_reg(dev, p, 8'h00, 1'b0, n);
    start_c();
    byte_io({dev, 1'b1}, x, n);
    byte_io(8'hff, q, n);
    stop_c();
  endtask
endmodule // smbus_host
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] DEV = 7'h2d;
  localparam logic [7:0] RV [8] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h00, 8'h00};
  logic       clk, rstn, sda_oe, scl, chain_n, bt_n, intr, hot, ot;
  logic [6:0] ch;
  logic [1:0] fan;
  logic       intr_oe, irq, irq_oe, rst_n_out, gpo_oe, run, nak;
  wire        sda;
  int         miscompares, cmp_count, intr_cnt, rst_cnt;
  monitor_ctrl #(.INTRUSION_CLR_CYCLES(20), .RESET_PULSE_CYCLES(5)) i_monitor_ctrl (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe),
    .i_addr_pins(3'b101), .i_channel_limit(ch), .i_hot_limit(hot), .i_fan_limit(fan),
    .i_overtemp_limit(ot), .i_chain_irq_n(chain_n), .i_board_temp_irq_input(bt_n),
    .i_intrusion_input(intr), .o_intrusion_oe(intr_oe), .o_irq_out(irq),
    .o_irq_oe(irq_oe), .o_reset_out_n(rst_n_out), .o_general_output_pin_oe(gpo_oe),
    .o_monitor_run(run));
  smbus_host i_smbus_host (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    intr_cnt += int'(intr_oe === 1'b1);
    rst_cnt += int'(rst_n_out === 1'b0);
  end
  task automatic check(input logic [7:0] s, e, input string m);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic flag(input logic s, e, input string m);
    check({7'h0, s}, {7'h0, e}, m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] p, e, input string m);
    logic [7:0] q;
    i_smbus_host.read_reg(DEV, p, q);
    check(q, e, m);
  endtask
  task automatic wr(input logic [7:0] p, d);
    logic n;
    i_smbus_host.write_reg(DEV, p, d, 1'b1, n);
    flag(n, 1'b0, "no ack");
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #800us;
    miscompares++;
    summarize();
  end
  initial begin
    {rstn, chain_n, bt_n, intr, hot, ot, ch, fan} = {1'b1, 1'b1, 1'b1, 12'h0};
    // Fall after time zero so the asynchronous reset sees a real edge
    #1 rstn = 1'b0;
    cyc(20);
    rstn = 1'b1;
    cyc(4);
    for (int i = 0; i < 8; i++) begin
      rd(i[7:0], RV[i], "reset value");
    end
    $display("test reset_values done");
    ch = 7'h05;
    cyc(3);
    ch = 7'h00;
    rd(8'h01, 8'h00, "set while halted");
    wr(8'h00, 8'h01);
    flag(run, 1'b1, "run");
    ch = 7'h45;
    cyc(3);
    ch = 7'h00;
    cyc(2);
    flag(irq_oe, 1'b0, "irq while disabled");
    wr(8'h00, 8'h03);
    flag(irq_oe, 1'b1, "irq on");
    flag(irq, 1'b0, "active low");
    rd(8'h01, 8'h45, "channel flags");
    flag(irq_oe, 1'b0, "irq after read");
    wr(8'h00, 8'h07);
    ch = 7'h01;
    cyc(3);
    ch = 7'h00;
    cyc(2);
    flag(irq, 1'b1, "active high");
    wr(8'h00, 8'h0f);
    flag(irq_oe, 1'b0, "irq cleared");
    flag(run, 1'b0, "paused");
    rd(8'h01, 8'h01, "status kept");
    $display("test run_and_irq done");
    wr(8'h00, 8'h03);
    wr(8'h03, 8'h80);
    chain_n = 1'b0;
    cyc(3);
    chain_n = 1'b1;
    cyc(2);
    flag(irq_oe, 1'b0, "chain masked");
    rd(8'h01, 8'h80, "chain flag");
    wr(8'h03, 8'h00);
    bt_n = 1'b0;
    cyc(3);
    bt_n = 1'b1;
    cyc(2);
    flag(irq_oe, 1'b1, "board temp irq");
    rd(8'h02, 8'h02, "board temp flag");
    wr(8'h04, 8'h3f);
    {intr, fan, hot, ot} = 5'h1f;
    cyc(3);
    {intr, fan, hot, ot} = 5'h00;
    cyc(2);
    flag(irq_oe, 1'b0, "second mask");
    rd(8'h02, 8'h3d, "second flags");
    for (int m = 0; m < 4; m++) begin
      wr(8'h04, {m[1:0], 6'h3f});
      {hot, ot} = 2'b11;
      cyc(3);
      rd(8'h02, 8'h21, "mode first");
      rd(8'h02, {2'b00, ~m[1], 4'h0, ~m[0]}, "mode again");
      {hot, ot} = 2'b00;
    end
    $display("test status_and_masks done");
    wr(8'h00, 8'h43);
    flag(gpo_oe, 1'b1, "general output");
    wr(8'h00, 8'h23);
    flag(gpo_oe, 1'b0, "general output off");
    rd(8'h00, 8'h03, "chassis self clear");
    check(intr_cnt[7:0], 8'd20, "chassis pulse");
    wr(8'h00, 8'h13);
    rd(8'h00, 8'h03, "reset gated");
    check(rst_cnt[7:0], 8'd0, "no reset pulse");
    wr(8'h05, 8'hc0);
    wr(8'h00, 8'h13);
    rd(8'h00, 8'h03, "reset gated both");
    wr(8'h05, 8'h80);
    wr(8'h00, 8'h13);
    rd(8'h00, 8'h03, "reset self clear");
    check(rst_cnt[7:0], 8'd5, "reset pulse");
    $display("test pins done");
    wr(8'h03, 8'h5a);
    wr(8'h00, 8'h80);
    rd(8'h03, 8'h00, "restored mask");
    rd(8'h05, 8'h14, "restored divisor");
    rd(8'h00, 8'h08, "restored config");
    i_smbus_host.write_reg(7'h28, 8'h00, 8'h01, 1'b1, nak);
    flag(nak, 1'b1, "foreign address");
    rd(8'h00, 8'h08, "foreign write ignored");
    $display("test restore_and_address done");
    summarize();
  end
endmodule // tb
`default_nettype wire
